/* File: hw/eeaw_dev_end.sv */
// eeaw_dev_end: device end of the two-wire serial memory, addressing, writes, reads.
// assumes scl/sda come from the link and are sampled by i_clk_sys (much faster).
// Operation
// - array is 1024 pages of 256 bytes
// - accept only type identifier 1010 in bits 7:4
// - bit 3 must equal select pin level
// - bits 2:1 give address bits 17:16
// - bit 0 one reads, zero writes
// - ack on match, else nack and standby
// - two word address bytes follow, high first
// - byte address is 18 bits concatenated
// - byte write acked, stop starts programming
// - ignore the bus while programming
// - page write up to 256 bytes, same page
// - up to 255 more bytes, each acked
// - only low eight address bits increment, wrapping
// - host should avoid wrapping within a page
// - words hold four bytes plus six check bits
// - reads correct any single bit error
// - any write reprograms whole four-byte word
// - no address ack during programming
// - host may poll with address until ack
// - protect pin high blocks all programming
// - protect pin sampled at the ending stop
// - protected write acked, stop skips programming
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module eeaw_dev_end #(
	parameter int P_PROG_CYCLES = eeaw_pkg::PROG_CYCLES
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	eeaw_link_if.dev bus,
	input wire logic i_hw_select_bit,
	input wire logic i_write_protect,
	output logic o_busy
);
	localparam int PCW = $clog2(P_PROG_CYCLES + 1);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV = 3'b001,
		ST_WA1 = 3'b010,
		ST_WA2 = 3'b011,
		ST_WDATA = 3'b100,
		ST_RDATA = 3'b101,
		ST_PROG = 3'b110
	} eeaw_dst_e;

	// ==========================================================
	// pin synchronisers
	logic scl_s1_ff, scl_s2_ff, scl_d_ff;
	logic sda_s1_ff, sda_s2_ff, sda_d_ff;
	logic wp_s1_ff, wp_s2_ff;
	logic hw_s1_ff, hw_s2_ff;

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			{scl_s1_ff, scl_s2_ff, scl_d_ff} <= 3'h7;
			{sda_s1_ff, sda_s2_ff, sda_d_ff} <= 3'h7;
			{wp_s1_ff, wp_s2_ff, hw_s1_ff, hw_s2_ff} <= 4'h0;
		end else begin
			{scl_s1_ff, scl_s2_ff, scl_d_ff} <= {bus.scl, scl_s1_ff, scl_s2_ff};
			{sda_s1_ff, sda_s2_ff, sda_d_ff} <= {bus.sda, sda_s1_ff, sda_s2_ff};
			{wp_s1_ff, wp_s2_ff} <= {i_write_protect, wp_s1_ff};
			{hw_s1_ff, hw_s2_ff} <= {i_hw_select_bit, hw_s1_ff};
		end
	end

	wire scl_rise = scl_s2_ff & ~scl_d_ff;
	wire scl_fall = ~scl_s2_ff & scl_d_ff;
	wire start_ev = scl_s2_ff & scl_d_ff & sda_d_ff & ~sda_s2_ff;
	wire stop_ev = scl_s2_ff & scl_d_ff & ~sda_d_ff & sda_s2_ff;

	// ==========================================================
	// state
	eeaw_dst_e state_ff;
	logic [3:0] bit_cnt_ff;
	logic [7:0] shift_ff;
	logic [7:0] rd_byte_ff;
	logic [7:0] wa1_ff;
	logic [1:0] hi_ff;
	logic [eeaw_pkg::ADDR_W-1:0] addr_ff;
	logic [eeaw_pkg::PAGE_BYTES-1:0] pval_ff;
	logic loaded_ff;
	logic sda_low_ff;
	logic busy_ff;
	logic [PCW-1:0] prog_cnt_ff;
	logic [7:0] pbuf [0:eeaw_pkg::PAGE_BYTES-1];
	logic [eeaw_pkg::PHYS_W-1:0] mem [0:eeaw_pkg::PHYS_WORDS-1];

	// ==========================================================
	// decode of the received byte
	wire dev_match = (shift_ff[7:eeaw_pkg::DEVB_TYPE_LSB] == eeaw_pkg::DEV_TYPE_ID) &&
		(shift_ff[eeaw_pkg::DEVB_HW_SEL] == hw_s2_ff);
	wire dev_read = shift_ff[eeaw_pkg::DEVB_RW];
	wire byte_done = scl_fall && (bit_cnt_ff == 4'h8);
	wire ack_done = scl_fall && (bit_cnt_ff == 4'h9);
	wire data_we = byte_done && (state_ff == ST_WDATA);
	wire prog_last = (prog_cnt_ff == PCW'(P_PROG_CYCLES - 1));

	// ==========================================================
	// read path with single-bit correction
	wire [31:0] rd_word = eeaw_pkg::eeaw_fix(mem[addr_ff[eeaw_pkg::ADDR_W-1:2]]);
	wire [7:0] rd_sel = rd_word[{addr_ff[1:0], 3'b000} +: 8];

	// ==========================================================
	// programming walks the 64 words of the page, one per clock
	wire [15:0] prg_widx = {addr_ff[eeaw_pkg::ADDR_W-1:8], prog_cnt_ff[5:0]};
	wire [3:0] prg_lanes = pval_ff[{prog_cnt_ff[5:0], 2'b00} +: 4];
	wire prg_we = (state_ff == ST_PROG) && (prog_cnt_ff < PCW'(eeaw_pkg::PAGE_WORDS)) &&
		(|prg_lanes);
	wire [31:0] prg_old = eeaw_pkg::eeaw_fix(mem[prg_widx]);
	logic [31:0] prg_new;

	always_comb begin
		prg_new = prg_old;
		for (int b = 0; b < eeaw_pkg::WORD_BYTES; b++) begin
			if (prg_lanes[b]) prg_new[b*8 +: 8] = pbuf[{prog_cnt_ff[5:0], 2'(b)}];
		end
	end

	// untouched bytes of the word are rewritten from corrected old data
	always_ff @(posedge i_clk_sys) begin
		if (prg_we) begin
			mem[prg_widx] <= {eeaw_pkg::eeaw_ecc(prg_new), prg_new};
		end
		if (data_we) begin
			pbuf[addr_ff[7:0]] <= shift_ff;
		end
	end

	// ==========================================================
	// protocol engine
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff <= ST_IDLE;
			bit_cnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			rd_byte_ff <= 8'h00;
			wa1_ff <= 8'h00;
			hi_ff <= 2'h0;
			addr_ff <= 18'h0_0000;
			pval_ff <= '0;
			loaded_ff <= 1'b0;
			sda_low_ff <= 1'b0;
			busy_ff <= 1'b0;
			prog_cnt_ff <= '0;
		end else if (state_ff == ST_PROG) begin
			// bus fully ignored, no ack even for own address
			sda_low_ff <= 1'b0;
			if (prog_last) begin
				state_ff <= ST_IDLE;
				busy_ff <= 1'b0;
			end else begin
				prog_cnt_ff <= prog_cnt_ff + 1'b1;
			end
		end else if (start_ev) begin
			state_ff <= ST_DEV;
			bit_cnt_ff <= 4'h0;
			sda_low_ff <= 1'b0;
		end else if (stop_ev) begin
			bit_cnt_ff <= 4'h0;
			sda_low_ff <= 1'b0;
			// protect level taken here only; later changes are ignored
			if (state_ff == ST_WDATA && loaded_ff && !wp_s2_ff) begin
				state_ff <= ST_PROG;
				busy_ff <= 1'b1;
				prog_cnt_ff <= '0;
			end else begin
				state_ff <= ST_IDLE;
			end
		end else if (state_ff != ST_IDLE) begin
			if (scl_rise && bit_cnt_ff < 4'h8) begin
				shift_ff <= {shift_ff[6:0], sda_s2_ff};
				bit_cnt_ff <= bit_cnt_ff + 1'b1;
			end else if (scl_rise) begin
				bit_cnt_ff <= 4'h9;
				if (state_ff == ST_RDATA && sda_s2_ff) state_ff <= ST_IDLE;
			end else if (byte_done) begin
				sda_low_ff <= (state_ff != ST_RDATA) && (state_ff != ST_DEV || dev_match);
				case (state_ff)
					ST_DEV: begin
						if (!dev_match) begin
							state_ff <= ST_IDLE;
						end else if (dev_read) begin
							state_ff <= ST_RDATA;
						end else begin
							state_ff <= ST_WA1;
							hi_ff <= shift_ff[eeaw_pkg::DEVB_BIT_17:eeaw_pkg::DEVB_BIT_16];
						end
					end
					ST_WA1: begin
						wa1_ff <= shift_ff;
						state_ff <= ST_WA2;
					end
					ST_WA2: begin
						addr_ff <= {hi_ff, wa1_ff, shift_ff};
						state_ff <= ST_WDATA;
						pval_ff <= '0;
						loaded_ff <= 1'b0;
					end
					ST_WDATA: begin
						// page bits stay, low byte wraps inside the page
						pval_ff[addr_ff[7:0]] <= 1'b1;
						addr_ff[7:0] <= addr_ff[7:0] + 8'h01;
						loaded_ff <= 1'b1;
					end
					default: begin
						state_ff <= state_ff;
					end
				endcase
			end else if (ack_done) begin
				bit_cnt_ff <= 4'h0;
				if (state_ff == ST_RDATA) begin
					rd_byte_ff <= rd_sel;
					sda_low_ff <= ~rd_sel[7];
					addr_ff <= addr_ff + 18'h0_0001;
				end else begin
					sda_low_ff <= 1'b0;
				end
			end else if (scl_fall && state_ff == ST_RDATA && bit_cnt_ff != 4'h0) begin
				sda_low_ff <= ~rd_byte_ff[3'(4'h7 - bit_cnt_ff)];
			end
		end
	end

	assign bus.sda_d_o = 1'b0;
	assign bus.sda_d_oe_n = ~sda_low_ff;
	assign o_busy = busy_ff;
endmodule : eeaw_dev_end
`default_nettype wire

/* File: hw/eeaw_pkg.sv */
// eeaw_pkg: constants, layouts and check-bit functions shared by both link ends.
// assumes a single 20 MHz system clock on both ends.
package eeaw_pkg;
	// ==========================================================
	// timebase
	localparam int CLK_MHZ = 20;
	localparam int CLK_PERIOD_NS = 50;
	localparam int PROGRAM_CYCLE_TIME_US = 10000;
	localparam int PROG_CYCLES = PROGRAM_CYCLE_TIME_US * CLK_MHZ;
	localparam int SCL_QUARTER_NS = 250;
	localparam int SCL_QUARTER_CYC = (SCL_QUARTER_NS / CLK_PERIOD_NS < 1) ? 1 :
		SCL_QUARTER_NS / CLK_PERIOD_NS;
	// ==========================================================
	// array organisation
	localparam int PAGE_COUNT = 1024;
	localparam int PAGE_BYTES = 256;
	localparam int ADDR_W = 18;
	localparam int WORD_BYTES = 4;
	localparam int CHK_W = 6;
	localparam int PHYS_W = 38;
	localparam int PHYS_WORDS = PAGE_COUNT * PAGE_BYTES / WORD_BYTES;
	localparam int PAGE_WORDS = PAGE_BYTES / WORD_BYTES;
	// ==========================================================
	// device address byte layout
	localparam logic [3:0] DEV_TYPE_ID = 4'ha;
	localparam int DEVB_TYPE_LSB = 4;
	localparam int DEVB_HW_SEL = 3;
	localparam int DEVB_BIT_17 = 2;
	localparam int DEVB_BIT_16 = 1;
	localparam int DEVB_RW = 0;
	// ==========================================================
	// host register map and fields
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_TX = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_WRITE = 2;
	localparam int CMD_READ = 3;
	localparam int CMD_NACK = 4;
	localparam int STAT_BUSY = 8;
	localparam int STAT_ACK = 9;
	// ==========================================================
	// single-error-correcting code over 32 data bits
	function automatic logic [5:0] eeaw_code(input int idx);
		logic [5:0] code;
		int n;
		code = 6'h00;
		n = 0;
		for (int pos = 3; pos <= PHYS_W; pos++) begin
			if ((pos & (pos - 1)) != 0) begin
				if (n == idx) code = 6'(pos);
				n++;
			end
		end
		return code;
	endfunction : eeaw_code

	function automatic logic [5:0] eeaw_ecc(input logic [31:0] d);
		logic [5:0] chk;
		chk = 6'h00;
		for (int i = 0; i < 32; i++) begin
			if (d[i]) chk = chk ^ eeaw_code(i);
		end
		return chk;
	endfunction : eeaw_ecc

	function automatic logic [31:0] eeaw_fix(input logic [37:0] w);
		logic [5:0] syn;
		logic [31:0] d;
		d = w[31:0];
		syn = w[37:32] ^ eeaw_ecc(w[31:0]);
		for (int i = 0; i < 32; i++) begin
			if (syn == eeaw_code(i)) d[i] = ~d[i];
		end
		return d;
	endfunction : eeaw_fix
endpackage : eeaw_pkg

/* File: hw/eeaw_link_if.sv */
// eeaw_link_if: two-wire link between host end and device end.
// assumes pull-ups: a released line reads high; any enabled driver pulls it low.
`timescale 1ns/1ns
`default_nettype none
interface eeaw_link_if;
	logic scl_m_o;
	logic scl_m_oe_n;
	logic sda_m_o;
	logic sda_m_oe_n;
	logic sda_d_o;
	logic sda_d_oe_n;
	logic scl;
	logic sda;
	assign scl = scl_m_oe_n | scl_m_o;
	assign sda = (sda_m_oe_n | sda_m_o) & (sda_d_oe_n | sda_d_o);
	modport host (output scl_m_o, output scl_m_oe_n, output sda_m_o, output sda_m_oe_n,
		input scl, input sda);
	modport dev (output sda_d_o, output sda_d_oe_n, input scl, input sda);
endinterface : eeaw_link_if
`default_nettype wire

/* File: hw/eeaw_host_end.sv */
// eeaw_host_end: two-wire bus master driven by software through a small register port.
// assumes the device end answers within one scl quarter after an scl fall.
`timescale 1ns/1ns
`default_nettype none
module eeaw_host_end (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	eeaw_link_if.host bus,
	input wire logic [7:0] i_reg_addr,
	input wire logic [31:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [31:0] o_reg_rdata
);
	localparam int DCW = $clog2(eeaw_pkg::SCL_QUARTER_CYC + 1);

	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_START = 2'b01,
		PH_BIT = 2'b10,
		PH_STOP = 2'b11
	} eeaw_hph_e;

	eeaw_hph_e ph_ff;
	logic [4:0] cmd_ff;
	logic [7:0] tx_ff, rx_ff;
	logic ack_ff, busy_ff;
	logic [1:0] q_ff;
	logic [3:0] bit_ff;
	logic [DCW-1:0] div_ff;
	logic scl_oe_n_ff, sda_oe_n_ff;
	logic sda_s1_ff, sda_s2_ff;
	logic [31:0] rdata_ff;

	// ==========================================================
	// register decode
	wire wr_cmd = i_reg_wr && (i_reg_addr == eeaw_pkg::REG_CMD) && !busy_ff;
	wire wr_tx = i_reg_wr && (i_reg_addr == eeaw_pkg::REG_TX) && !busy_ff;
	wire rd_stat = i_reg_rd && (i_reg_addr == eeaw_pkg::REG_STAT);
	wire [31:0] stat_word = {22'h00_0000, ack_ff, busy_ff, rx_ff};
	wire tick = (div_ff == DCW'(eeaw_pkg::SCL_QUARTER_CYC - 1));
	wire is_wr = cmd_ff[eeaw_pkg::CMD_WRITE];
	wire bit_drive_low = is_wr ? (bit_ff < 4'h8 && !tx_ff[3'(4'h7 - bit_ff)]) :
		(bit_ff == 4'h8 && !cmd_ff[eeaw_pkg::CMD_NACK]);

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			{sda_s1_ff, sda_s2_ff} <= 2'h3;
			rdata_ff <= 32'h0000_0000;
		end else begin
			{sda_s1_ff, sda_s2_ff} <= {bus.sda, sda_s1_ff};
			rdata_ff <= rd_stat ? stat_word : 32'h0000_0000;
		end
	end

	// ==========================================================
	// byte engine: start, then one byte, then stop, each optional
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			ph_ff <= PH_IDLE;
			cmd_ff <= 5'h00;
			tx_ff <= 8'h00;
			rx_ff <= 8'h00;
			ack_ff <= 1'b0;
			busy_ff <= 1'b0;
			q_ff <= 2'h0;
			bit_ff <= 4'h0;
			div_ff <= '0;
			scl_oe_n_ff <= 1'b1;
			sda_oe_n_ff <= 1'b1;
		end else if (ph_ff == PH_IDLE) begin
			div_ff <= '0;
			q_ff <= 2'h0;
			bit_ff <= 4'h0;
			if (wr_tx) tx_ff <= i_reg_wdata[7:0];
			if (wr_cmd) begin
				cmd_ff <= i_reg_wdata[4:0];
				busy_ff <= |i_reg_wdata[3:0];
			end else if (busy_ff) begin
				if (cmd_ff[eeaw_pkg::CMD_START]) begin
					ph_ff <= PH_START;
				end else if (cmd_ff[eeaw_pkg::CMD_WRITE] || cmd_ff[eeaw_pkg::CMD_READ]) begin
					ph_ff <= PH_BIT;
				end else if (cmd_ff[eeaw_pkg::CMD_STOP]) begin
					ph_ff <= PH_STOP;
				end else begin
					busy_ff <= 1'b0;
				end
			end
		end else if (!tick) begin
			div_ff <= div_ff + 1'b1;
		end else begin
			div_ff <= '0;
			q_ff <= q_ff + 2'h1;
			case (ph_ff)
				PH_START: begin
					if (q_ff == 2'h0) sda_oe_n_ff <= 1'b1;
					if (q_ff == 2'h1) scl_oe_n_ff <= 1'b1;
					if (q_ff == 2'h2) sda_oe_n_ff <= 1'b0;
					if (q_ff == 2'h3) begin
						scl_oe_n_ff <= 1'b0;
						cmd_ff[eeaw_pkg::CMD_START] <= 1'b0;
						ph_ff <= PH_IDLE;
					end
				end
				PH_BIT: begin
					if (q_ff == 2'h0) sda_oe_n_ff <= ~bit_drive_low;
					if (q_ff == 2'h1) scl_oe_n_ff <= 1'b1;
					if (q_ff == 2'h2 && is_wr && bit_ff == 4'h8) ack_ff <= ~sda_s2_ff;
					if (q_ff == 2'h2 && !is_wr && bit_ff < 4'h8) rx_ff <= {rx_ff[6:0], sda_s2_ff};
					if (q_ff == 2'h3) begin
						scl_oe_n_ff <= 1'b0;
						bit_ff <= bit_ff + 4'h1;
						if (bit_ff == 4'h8) begin
							cmd_ff[eeaw_pkg::CMD_WRITE] <= 1'b0;
							cmd_ff[eeaw_pkg::CMD_READ] <= 1'b0;
							ph_ff <= PH_IDLE;
						end
					end
				end
				default: begin
					if (q_ff == 2'h0) sda_oe_n_ff <= 1'b0;
					if (q_ff == 2'h1) scl_oe_n_ff <= 1'b1;
					if (q_ff == 2'h2) sda_oe_n_ff <= 1'b1;
					if (q_ff == 2'h3) begin
						cmd_ff[eeaw_pkg::CMD_STOP] <= 1'b0;
						ph_ff <= PH_IDLE;
					end
				end
			endcase
		end
	end

	assign bus.scl_m_o = 1'b0;
	assign bus.sda_m_o = 1'b0;
	assign bus.scl_m_oe_n = scl_oe_n_ff;
	assign bus.sda_m_oe_n = sda_oe_n_ff;
	assign o_reg_rdata = rdata_ff;
endmodule : eeaw_host_end
`default_nettype wire

/* File: sim/eeaw_sva.sv */
// eeaw_sva: timing checks on the two-wire link between host end and device end.
// assumes it is instantiated beside the link interface, on the system clock.
`timescale 1ns/1ns
`default_nettype none
module eeaw_sva #(
	parameter int P_PROG_CYCLES = 200
) (
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_sda_d_oe_n,
	input wire logic i_write_protect,
	input wire logic i_busy
);
	// ==========================================================
	// helpers: raw stop detect, busy length, distance from last stop
	logic sda_q_ff;
	logic [17:0] busy_cnt_ff;
	logic [3:0] since_stop_ff;
	wire logic stop_now;
	assign stop_now = i_scl & i_sda & ~sda_q_ff;
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			sda_q_ff <= 1'b1;
			busy_cnt_ff <= 18'h0_0000;
			since_stop_ff <= 4'hf;
		end else begin
			sda_q_ff <= i_sda;
			busy_cnt_ff <= i_busy ? busy_cnt_ff + 18'h0_0001 : 18'h0_0000;
			// saturates so a long idle never wraps back into the window
			since_stop_ff <= stop_now ? 4'h0 : (since_stop_ff == 4'hf) ? 4'hf : since_stop_ff + 4'h1;
		end
	end
	// ==========================================================
	// properties
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);
	sequence stop_s;
		stop_now;
	endsequence
	sequence prot_stop_s;
		stop_now && i_write_protect && !i_busy;
	endsequence
	sequence ack_rise_s;
		$rose(i_scl) && !i_sda_d_oe_n;
	endsequence
	busy_len_a: assert property ($fell(i_busy) |-> busy_cnt_ff >= P_PROG_CYCLES - 1
		&& busy_cnt_ff <= P_PROG_CYCLES + 1) else $error("programming length wrong");
	busy_quiet_a: assert property (i_busy |-> i_sda_d_oe_n)
		else $error("device drove sda while programming");
	prot_skip_a: assert property (prot_stop_s |=> !i_busy [*8])
		else $error("programming started while protected");
	prog_start_a: assert property ($rose(i_busy) |-> since_stop_ff <= 4'h8)
		else $error("programming started without a stop");
	wp_late_a: assert property (i_busy && !$stable(i_write_protect) |=> i_busy)
		else $error("protect change cut programming");
	ack_edge_a: assert property ($changed(i_sda_d_oe_n) |-> !i_scl)
		else $error("device changed sda while scl high");
	ack_hold_a: assert property (ack_rise_s |=> !i_sda_d_oe_n [*6])
		else $error("device released sda during scl high");
	stop_idle_a: assert property (stop_s |=> i_sda_d_oe_n [*4])
		else $error("device drove sda after stop");
endmodule : eeaw_sva
`default_nettype wire

/* File: sim/test_serial_eeprom_address_write_ctrl.sv */
// test_serial_eeprom_address_write_ctrl: host end and device end joined over the link.
// assumes the host register map and command bits of eeaw_pkg.
`timescale 1ns/1ns
`default_nettype none
module test_serial_eeprom_address_write_ctrl;
	// shortened programming time keeps polls shorter than one cycle of it
	localparam int PROG = 1000;
	localparam int LIMIT = 80000;
	localparam logic [4:0] C_SW = 5'h05;
	localparam logic [4:0] C_W = 5'h04;
	localparam logic [4:0] C_WS = 5'h06;
	localparam logic [4:0] C_S = 5'h02;
	localparam logic [4:0] C_R = 5'h08;
	localparam logic [4:0] C_RNS = 5'h1a;
	logic i_clk_sys;
	logic i_resetn;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic hw_sel;
	logic wp;
	logic busy;
	int n_mismatch;
	int tests_run;
	int cyc;
	eeaw_link_if eeaw_link_if_i ();
	eeaw_host_end eeaw_host_end_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
		.bus(eeaw_link_if_i.host), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
		.i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata));
	eeaw_dev_end #(.P_PROG_CYCLES(PROG)) eeaw_dev_end_i (.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn), .bus(eeaw_link_if_i.dev), .i_hw_select_bit(hw_sel),
		.i_write_protect(wp), .o_busy(busy));
	eeaw_sva #(.P_PROG_CYCLES(PROG)) eeaw_sva_i (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
		.i_scl(eeaw_link_if_i.scl), .i_sda(eeaw_link_if_i.sda),
		.i_sda_d_oe_n(eeaw_link_if_i.sda_d_oe_n), .i_write_protect(wp), .i_busy(busy));
	// ==========================================================
	// shared tasks
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge i_clk_sys);
		reg_wr <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge i_clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : bus_rd
	task automatic xfer(input logic [4:0] cmd, input logic [7:0] tx, output logic [31:0] st);
		int n;
		if (cmd[2]) bus_wr(eeaw_pkg::REG_TX, {24'h00_0000, tx});
		bus_wr(eeaw_pkg::REG_CMD, {27'h000_0000, cmd});
		n = 0;
		do begin
			bus_rd(eeaw_pkg::REG_STAT, st);
			n++;
		end while (st[eeaw_pkg::STAT_BUSY] !== 1'b0 && n < 2000);
		if (n >= 2000) chk("host busy", 32'h0000_0000, 32'h0000_0001);
	endtask : xfer
	task automatic send(input string what, input logic [4:0] cmd, input logic [7:0] tx,
		input logic ack);
		logic [31:0] st;
		xfer(cmd, tx, st);
		chk(what, {31'h0000_0000, ack}, {31'h0000_0000, st[eeaw_pkg::STAT_ACK]});
	endtask : send
	function automatic logic [7:0] devb(input logic [17:0] a, input logic rd);
		return {4'ha, hw_sel, a[17:16], rd};
	endfunction : devb
	task automatic addr_phase(input logic [17:0] a);
		send("dev write", C_SW, devb(a, 1'b0), 1'b1);
		send("addr high", C_W, a[15:8], 1'b1);
		send("addr low", C_W, a[7:0], 1'b1);
	endtask : addr_phase
	task automatic write_seq(input logic [17:0] a, input logic [7:0] d0, input int n);
		addr_phase(a);
		for (int i = 0; i < n; i++) send("data", (i == n - 1) ? C_WS : C_W, d0 + 8'(i), 1'b1);
	endtask : write_seq
	task automatic read_at(input logic [17:0] a, input logic [7:0] exp);
		logic [31:0] st;
		addr_phase(a);
		send("dev read", C_SW, devb(a, 1'b1), 1'b1);
		xfer(C_RNS, 8'h00, st);
		chk("read data", {24'h00_0000, exp}, {24'h00_0000, st[7:0]});
	endtask : read_at
	task automatic wait_busy(input logic lvl, input int lim, input string what);
		int n;
		n = 0;
		while (busy !== lvl && n < lim) begin
			@(posedge i_clk_sys);
			#1 n++;
		end
		chk(what, {31'h0000_0000, lvl}, {31'h0000_0000, busy});
	endtask : wait_busy
	// ==========================================================
	// scenarios
	task automatic s_byte_write();
		logic [31:0] st;
		write_seq(18'h2_1234, 8'h5a, 1);
		wait_busy(1'b1, 60, "busy rise");
		send("poll busy", C_SW, devb(18'h2_1234, 1'b0), 1'b0);
		xfer(C_S, 8'h00, st);
		wait_busy(1'b0, PROG + 50, "busy fall");
		send("poll done", C_SW, devb(18'h2_1234, 1'b0), 1'b1);
		xfer(C_S, 8'h00, st);
		write_seq(18'h1_1234, 8'hc3, 1);
		wait_busy(1'b1, 60, "busy rise");
		wait_busy(1'b0, PROG + 50, "busy fall");
		read_at(18'h2_1234, 8'h5a);
		read_at(18'h1_1234, 8'hc3);
	endtask : s_byte_write
	task automatic s_refuse();
		logic [31:0] st;
		send("bad type", C_SW, {4'hb, hw_sel, 3'b000}, 1'b0);
		xfer(C_S, 8'h00, st);
		send("bad select", C_SW, {4'ha, ~hw_sel, 3'b000}, 1'b0);
		xfer(C_S, 8'h00, st);
		@(posedge i_clk_sys);
		hw_sel <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		read_at(18'h2_1234, 8'h5a);
		@(posedge i_clk_sys);
		hw_sel <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
	endtask : s_refuse
	task automatic s_page_wrap();
		logic [31:0] st;
		write_seq(18'h0_05fe, 8'h10, 3);
		wait_busy(1'b1, 60, "busy rise");
		@(posedge i_clk_sys);
		wp <= 1'b1;
		wait_busy(1'b0, PROG + 50, "busy fall");
		@(posedge i_clk_sys);
		wp <= 1'b0;
		read_at(18'h0_0500, 8'h12);
		read_at(18'h0_05ff, 8'h11);
		// read with ack keeps the device sending the next location
		addr_phase(18'h0_05fe);
		send("dev read", C_SW, devb(18'h0_05fe, 1'b1), 1'b1);
		xfer(C_R, 8'h00, st);
		chk("seq first", 32'h0000_0010, {24'h00_0000, st[7:0]});
		xfer(C_RNS, 8'h00, st);
		chk("seq second", 32'h0000_0011, {24'h00_0000, st[7:0]});
	endtask : s_page_wrap
	task automatic s_correct();
		logic [31:0] d;
		logic [37:0] w;
		d = 32'h5a3c_c3a5;
		w = {eeaw_pkg::eeaw_ecc(d), d};
		chk("clean word", d, eeaw_pkg::eeaw_fix(w));
		for (int i = 0; i < eeaw_pkg::PHYS_W; i++) begin
			chk("corrected word", d, eeaw_pkg::eeaw_fix(w ^ (38'h00_0000_0001 << i)));
		end
	endtask : s_correct
	task automatic s_protect();
		logic [31:0] st;
		@(posedge i_clk_sys);
		wp <= 1'b1;
		write_seq(18'h2_1234, 8'hee, 1);
		repeat (60) @(posedge i_clk_sys);
		chk("busy protected", 32'h0000_0000, {31'h0000_0000, busy});
		send("ready at once", C_SW, devb(18'h2_1234, 1'b0), 1'b1);
		xfer(C_S, 8'h00, st);
		@(posedge i_clk_sys);
		wp <= 1'b0;
		read_at(18'h2_1234, 8'h5a);
	endtask : s_protect
	// ==========================================================
	// clock, watchdog, main sequence
	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_mismatch++;
			complete_run();
		end
	end
	initial begin
		i_resetn = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		hw_sel = 1'b1;
		wp = 1'b0;
		n_mismatch = 0;
		tests_run = 0;
		cyc = 0;
		repeat (16) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		s_byte_write();
		s_refuse();
		s_page_wrap();
		s_protect();
		s_correct();
		complete_run();
	end
endmodule : test_serial_eeprom_address_write_ctrl
`default_nettype wire
